/* include/als_pkg.sv */
// Purpose: shared constants for the aux link training snoop registers
// Assumes: byte-wide register data, 20-bit aux addresses
// Notes:   readback encodings differ from write encodings on purpose
package als_pkg;
  // monitored aux addresses
  localparam logic [19:0] ADDR_LINK_RATE  = 20'h00100;
  localparam logic [19:0] ADDR_LANE_CNT   = 20'h00101;
  localparam logic [19:0] ADDR_LANE0_DRV  = 20'h00103;
  localparam logic [19:0] ADDR_LANE1_DRV  = 20'h00104;
  localparam logic [19:0] ADDR_LANE2_DRV  = 20'h00105;
  localparam logic [19:0] ADDR_POWER_ST   = 20'h00600;
  // link rate write codes
  localparam logic [7:0]  WR_RATE_162     = 8'h06;
  localparam logic [7:0]  WR_RATE_270     = 8'h0a;
  localparam logic [7:0]  WR_RATE_540     = 8'h14;
  // link rate read codes
  localparam logic [1:0]  RD_RATE_162     = 2'h0;
  localparam logic [1:0]  RD_RATE_270     = 2'h1;
  localparam logic [1:0]  RD_RATE_540     = 2'h2;
  // lane count field (bits 4:0) write codes and readback masks
  localparam int          LANE_FLD_W      = 5;
  localparam logic [4:0]  WR_LANES_0      = 5'h00;
  localparam logic [4:0]  WR_LANES_1      = 5'h01;
  localparam logic [4:0]  WR_LANES_2      = 5'h02;
  localparam logic [4:0]  WR_LANES_4      = 5'h04;
  localparam logic [3:0]  MASK_LANES_0    = 4'h0;
  localparam logic [3:0]  MASK_LANES_1    = 4'h1;
  localparam logic [3:0]  MASK_LANES_2    = 4'h3;
  localparam logic [3:0]  MASK_LANES_4    = 4'hf;
  // drive register field positions (write and read placement)
  localparam int          WR_SWING_LO     = 0;
  localparam int          WR_PRE_LO       = 3;
  localparam int          RD_SWING_LO     = 0;
  localparam int          RD_PRE_LO       = 2;
  localparam int          NUM_DRV_LANES   = 3;
  // power state command values: d3 standby, d0
  localparam logic [2:0]  PWR_D3          = 3'h2;
  localparam logic [2:0]  PWR_D0          = 3'h1;
  // aux native request commands
  localparam logic [3:0]  CMD_NATIVE_WR   = 4'h8;
  localparam logic [3:0]  CMD_NATIVE_RD   = 4'h9;
endpackage : als_pkg

/* include/als_txn_if.sv */
// Purpose: carries completed aux transactions to the register logic
// Assumes: one clock shared by both ends
// Notes:   commit is a one-cycle pulse, addr/data stand until next request
`timescale 1ns/1ns
`default_nettype none
interface als_txn_if;
  logic        commit;   // native write to some address completed
  logic [19:0] addr;     // captured request address
  logic [7:0]  data;     // captured write data
  modport src (output commit, output addr, output data);
  modport dst (input commit, input addr, input data);
endinterface : als_txn_if
`default_nettype wire

/* hw/als_txn.sv */
// Purpose: holds an aux request until its reply, flags completed writes
// Assumes: request and reply strobes come from aux phy logic on i_sys_clk
// Notes:   a nacked reply drops the write without committing
`timescale 1ns/1ns
`default_nettype none
module als_txn (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // decoded aux request
  input  wire logic        i_req_valid,
  input  wire logic [3:0]  i_req_cmd,
  input  wire logic [19:0] i_req_addr,
  input  wire logic [7:0]  i_req_data,
  // decoded aux reply
  input  wire logic        i_reply_ack,
  input  wire logic        i_reply_nack,
  // completed transactions
  als_txn_if.src           txn
);
  typedef enum logic {ALS_IDLE, ALS_WAIT} als_txn_e;

  als_txn_e    state_ff;   // waiting for the sink's reply or not
  logic        is_wr_ff;   // held request is a native write
  logic        commit_ff;  // completion pulse
  logic [19:0] addr_ff;    // held address
  logic [7:0]  data_ff;    // held data

  // request capture and reply tracking
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff  <= ALS_IDLE;
      is_wr_ff  <= 1'b0;
      commit_ff <= 1'b0;
      addr_ff   <= 20'h00000;
      data_ff   <= 8'h00;
    end else begin
      commit_ff <= 1'b0;
      case (state_ff)
        ALS_IDLE: begin
          if (i_req_valid) begin
            state_ff <= ALS_WAIT;
            is_wr_ff <= (i_req_cmd == als_pkg::CMD_NATIVE_WR);
            addr_ff  <= i_req_addr;
            data_ff  <= i_req_data;
          end
        end
        ALS_WAIT: begin
          // a write takes effect only once the sink acks it
          if (i_reply_ack) begin
            commit_ff <= is_wr_ff;
            state_ff  <= ALS_IDLE;
          end else if (i_reply_nack) begin
            state_ff  <= ALS_IDLE;
          end
        end
        default: state_ff <= ALS_IDLE;
      endcase
    end
  end

  assign txn.commit = commit_ff;
  assign txn.addr   = addr_ff;
  assign txn.data   = data_ff;
endmodule : als_txn
`default_nettype wire

/* hw/als_snoop.sv */
// Purpose: snoops aux link training writes and drives main link settings
// Assumes: aux phy decodes 1Mbps manchester requests on i_sys_clk
// Notes:   cable adapter detect is a pin and is synchronised first
//
// How it works
// - training writes in dp mode set drive
// - follow training only in manchester signalling mode
// - tmds mode (adapter detect high) disables observer
// - detect d3 standby power command
// - ignore values in reserved bit fields
// - link rate codes 06h, 0ah, 14h decoded
// - unknown link rate code selects 5.4 Gbps
// - link rate readback 00h/01h/02h
// - lane count field 0,1,2,4 lanes
// - invalid lane count turns lanes off
// - lane readback is thermometer mask
// - lane0 swing bits 1:0, pre-emphasis 4:3
// - forbidden drive pairs disable all lanes
// - drive readback: swing 1:0, pre-emphasis 3:2
// - lanes 1 and 2 drive registers too
`timescale 1ns/1ns
`default_nettype none
module als_snoop (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // mode inputs
  input  wire logic        i_cable_adapter_detect,
  input  wire logic        i_aux_manchester_mode,
  // decoded aux traffic
  input  wire logic        i_req_valid,
  input  wire logic [3:0]  i_req_cmd,
  input  wire logic [19:0] i_req_addr,
  input  wire logic [7:0]  i_req_data,
  input  wire logic        i_reply_ack,
  input  wire logic        i_reply_nack,
  // main link settings
  output logic [5:0]       o_output_swing_level,
  output logic [5:0]       o_preemph_level,
  output logic [5:0]       o_input_equalizer_setting,
  output logic [3:0]       o_lane_en,
  output logic [1:0]       o_link_rate,
  output logic             o_standby_d3,
  output logic             o_tmds_mode,
  // readback of the link rate, lane count and lane drive registers
  output logic [7:0]       o_rd_data
);
  localparam int NL = als_pkg::NUM_DRV_LANES;

  als_txn_if txn ();

  // all checks below run on the one system clock, quiet during reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  logic          cad_meta_ff;  // first synchroniser stage
  logic          cad_ff;       // synchronised adapter detect
  logic          obs_on;       // observer active
  logic          wr_ok;        // a monitored write may land
  logic [1:0]    rate_ff;      // link rate, read encoding
  logic [3:0]    mask_ff;      // lane thermometer mask
  logic          lane_bad_ff;  // invalid lane count seen
  logic [1:0]    swing_ff [NL];
  logic [1:0]    pre_ff   [NL];
  logic [NL-1:0] bad_ff;       // forbidden pair per lane
  logic          d3_ff;        // standby command seen

  als_txn u_txn (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_req_valid  (i_req_valid),
    .i_req_cmd    (i_req_cmd),
    .i_req_addr   (i_req_addr),
    .i_req_data   (i_req_data),
    .i_reply_ack  (i_reply_ack),
    .i_reply_nack (i_reply_nack),
    .txn          (txn.src)
  );

  // adapter detect is an async pin, two flops before use
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cad_meta_ff <= 1'b0;
      cad_ff      <= 1'b0;
    end else begin
      cad_meta_ff <= i_cable_adapter_detect;
      cad_ff      <= cad_meta_ff;
    end
  end

  // observer runs in dp mode with manchester aux only
  assign obs_on = !cad_ff && i_aux_manchester_mode;
  assign wr_ok  = obs_on && txn.commit;

  // link rate: unknown codes fall back to the top rate
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rate_ff <= als_pkg::RD_RATE_270;
    end else if (wr_ok && txn.addr == als_pkg::ADDR_LINK_RATE) begin
      if (txn.data == als_pkg::WR_RATE_162) begin
        rate_ff <= als_pkg::RD_RATE_162;
      end else if (txn.data == als_pkg::WR_RATE_270) begin
        rate_ff <= als_pkg::RD_RATE_270;
      end else begin
        rate_ff <= als_pkg::RD_RATE_540;
      end
    end
  end

  // lane count: only bits 4:0 count, the rest are reserved
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_ff     <= als_pkg::MASK_LANES_0;
      lane_bad_ff <= 1'b0;
    end else if (wr_ok && txn.addr == als_pkg::ADDR_LANE_CNT) begin
      lane_bad_ff <= 1'b0;
      case (txn.data[als_pkg::LANE_FLD_W-1:0])
        als_pkg::WR_LANES_0: mask_ff <= als_pkg::MASK_LANES_0;
        als_pkg::WR_LANES_1: mask_ff <= als_pkg::MASK_LANES_1;
        als_pkg::WR_LANES_2: mask_ff <= als_pkg::MASK_LANES_2;
        als_pkg::WR_LANES_4: mask_ff <= als_pkg::MASK_LANES_4;
        default: begin
          mask_ff     <= als_pkg::MASK_LANES_0;
          lane_bad_ff <= 1'b1;
        end
      endcase
    end
  end

  // per-lane drive registers at consecutive addresses from lane 0
  for (genvar g = 0; g < NL; g++) begin : g_drv
    logic [1:0] w_sw;
    logic [1:0] w_pe;
    logic       w_bad;
    logic       hit;
    assign hit  = wr_ok &&
                  txn.addr == als_pkg::ADDR_LANE0_DRV + 20'(g);
    assign w_sw = txn.data[als_pkg::WR_SWING_LO +: 2];
    assign w_pe = txn.data[als_pkg::WR_PRE_LO +: 2];
    // swing 2-3 with pre 2-3, or swing 1 with pre 3, is forbidden;
    // not a plain sum limit: swing 3 with pre 1 must stay legal
    assign w_bad = (w_sw[1] && w_pe[1]) ||
                   (w_sw == 2'h1 && w_pe == 2'h3);
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        swing_ff[g] <= 2'h0;
        pre_ff[g]   <= 2'h0;
        bad_ff[g]   <= 1'b0;
      end else if (hit) begin
        swing_ff[g] <= w_sw;
        pre_ff[g]   <= w_pe;
        bad_ff[g]   <= w_bad;
      end
    end
  end

  // d3 standby: power state writes, bits 2:0 only
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      d3_ff <= 1'b0;
    end else if (wr_ok && txn.addr == als_pkg::ADDR_POWER_ST) begin
      d3_ff <= (txn.data[2:0] == als_pkg::PWR_D3);
    end
  end

  // main link outputs, registered; eq follows pre-emphasis level
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_output_swing_level      <= 6'h00;
      o_preemph_level           <= 6'h00;
      o_input_equalizer_setting <= 6'h00;
      o_lane_en                 <= 4'h0;
      o_link_rate               <= als_pkg::RD_RATE_270;
      o_standby_d3              <= 1'b0;
      o_tmds_mode               <= 1'b0;
    end else begin
      o_output_swing_level      <= {swing_ff[2], swing_ff[1], swing_ff[0]};
      o_preemph_level           <= {pre_ff[2], pre_ff[1], pre_ff[0]};
      o_input_equalizer_setting <= {pre_ff[2], pre_ff[1], pre_ff[0]};
      // a forbidden pair or bad count blanks every lane until fixed
      o_lane_en    <= (lane_bad_ff || |bad_ff) ? 4'h0 : mask_ff;
      o_link_rate  <= rate_ff;
      o_standby_d3 <= d3_ff;
      o_tmds_mode  <= cad_ff;
    end
  end

  // readback follows the last request address, read encodings only
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 8'h00;
    end else if (txn.addr == als_pkg::ADDR_LINK_RATE) begin
      o_rd_data <= {6'h00, rate_ff};
    end else if (txn.addr == als_pkg::ADDR_LANE_CNT) begin
      o_rd_data <= {4'h0, mask_ff};
    end else if (txn.addr == als_pkg::ADDR_LANE0_DRV) begin
      o_rd_data <= {4'h0, pre_ff[0], swing_ff[0]};
    end else if (txn.addr == als_pkg::ADDR_LANE1_DRV) begin
      o_rd_data <= {4'h0, pre_ff[1], swing_ff[1]};
    end else if (txn.addr == als_pkg::ADDR_LANE2_DRV) begin
      o_rd_data <= {4'h0, pre_ff[2], swing_ff[2]};
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  sequence s_rate_wr(logic [7:0] v);
    wr_ok && txn.addr == als_pkg::ADDR_LINK_RATE && txn.data == v;
  endsequence

  a_rate_slow: assert property (
    s_rate_wr(als_pkg::WR_RATE_162) |=>
    ##1 o_link_rate == als_pkg::RD_RATE_162) else $error("rate 162");
  a_rate_fallback: assert property (wr_ok &&
    txn.addr == als_pkg::ADDR_LINK_RATE && txn.data == 8'h33 |=>
    ##1 o_link_rate == als_pkg::RD_RATE_540) else $error("fallback");
  // tmds mode must freeze the captured rate, lane mask and forbidden-pair flags, not only gate a strobe
  a_tmds_blocks: assert property (
    cad_ff |=> $stable(rate_ff) && $stable(mask_ff) && $stable(bad_ff))
    else $error("observer on in tmds");
  a_manch_only: assert property (
    !i_aux_manchester_mode |=> $stable(rate_ff) && $stable(mask_ff))
    else $error("observer on off manchester");
  a_lane_bad: assert property (wr_ok &&
    txn.addr == als_pkg::ADDR_LANE_CNT && txn.data[4:0] == 5'h03 |=>
    ##1 o_lane_en == 4'h0) else $error("bad lane count kept lanes");
  a_lane_four: assert property (wr_ok &&
    txn.addr == als_pkg::ADDR_LANE_CNT && txn.data == 8'he4 &&
    bad_ff == '0 |=> ##1 o_lane_en == 4'hf)
    else $error("four lanes not enabled");
  a_pair_bad: assert property (bad_ff != '0 |=> o_lane_en == 4'h0)
    else $error("forbidden pair left lanes on");
  a_pair_ok: assert property (wr_ok &&
    txn.addr == als_pkg::ADDR_LANE0_DRV && txn.data == 8'h0b |=>
    !bad_ff[0]) else $error("legal pair flagged");
  a_drv_rdback: assert property (wr_ok &&
    txn.addr == als_pkg::ADDR_LANE0_DRV && txn.data == 8'h09 |=>
    ##1 (o_rd_data == 8'h05 || $past(txn.addr) != als_pkg::ADDR_LANE0_DRV))
    else $error("drive readback placement");
  a_d3_seen: assert property (wr_ok &&
    txn.addr == als_pkg::ADDR_POWER_ST &&
    txn.data[2:0] == als_pkg::PWR_D3 |=> ##1 o_standby_d3)
    else $error("d3 not detected");
  a_no_commit: assert property (!txn.commit |=> $stable(rate_ff))
    else $error("rate changed without write");
endmodule : als_snoop
`default_nettype wire

/* dv/als_aux_model.sv */
// Purpose: aux source and sink model giving decoded request/reply strobes
// Assumes: one request outstanding, reply after a chosen wait
// Notes:   nack only when the bench asks; lines are scrambled once taken
`timescale 1ns/1ns
`default_nettype none
module als_aux_model (
  // clock
  input  wire logic        i_sys_clk,
  // decoded aux request
  output logic             o_req_valid,
  output logic [3:0]       o_req_cmd,
  output logic [19:0]      o_req_addr,
  output logic [7:0]       o_req_data,
  // decoded aux reply
  output logic             o_reply_ack,
  output logic             o_reply_nack
);
  // idle bus at time zero
  initial begin
    o_req_valid  = 1'h0;
    o_req_cmd    = 4'h0;
    o_req_addr   = 20'h00000;
    o_req_data   = 8'h00;
    o_reply_ack  = 1'h0;
    o_reply_nack = 1'h0;
  end
  // one transaction; gap is the sink's reply delay in cycles
  task automatic xfer(input logic [3:0] cmd, input logic [19:0] adr,
                      input logic [7:0] dat, input logic nak,
                      input int gap);
    @(posedge i_sys_clk);
    o_req_valid <= 1'h1;
    o_req_cmd   <= cmd;
    o_req_addr  <= adr;
    o_req_data  <= dat;
    @(posedge i_sys_clk);
    // taken: inverted lines catch a design that samples them late
    o_req_valid <= 1'h0;
    o_req_cmd   <= ~cmd;
    o_req_addr  <= ~adr;
    o_req_data  <= ~dat;
    repeat (gap) @(posedge i_sys_clk);
    if (nak) begin
      o_reply_nack <= 1'h1;
    end else begin
      o_reply_ack <= 1'h1;
    end
    @(posedge i_sys_clk);
    o_reply_ack  <= 1'h0;
    o_reply_nack <= 1'h0;
  endtask : xfer
endmodule : als_aux_model
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for the aux training snoop registers
// Assumes: outputs settle two edges after the sink's reply
// Notes:   table rows are cumulative; each row builds on the one before
`timescale 1ns/1ns
`default_nettype none
module tb;
  // row: address, byte, then rate, lanes, swing, pre, readback, flags
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [3:0]  rt;
    logic [3:0]  ln;
    logic [7:0]  sw;
    logic [7:0]  pe;
    logic [7:0]  rd;
    logic [3:0]  fl;  // bit1: drive and readback known, bit0: d3
  } als_row_s;
  logic        sys_clk;
  logic        reset_n;
  logic        cad;      // adapter detect pin
  logic        man;      // manchester signalling mode
  logic        rv, ak, nk;
  logic [3:0]  rc;
  logic [19:0] ra;
  logic [7:0]  rdt, rd_q;
  logic [5:0]  sw_q, pe_q, eq_q;
  logic [3:0]  ln_q;
  logic [1:0]  rt_q;
  logic        d3_q, tm_q;
  int          err_total = 0;
  int          compares = 0;
  als_row_s    r;
  als_row_s    rows [19] = '{
    56'h100_06_0_0_00_00_00_2, 56'h100_14_2_0_00_00_02_2,
    56'h100_0a_1_0_00_00_01_2, 56'h100_33_2_0_00_00_02_2,
    56'h101_01_2_1_00_00_01_2, 56'h101_e2_2_3_00_00_03_2,
    56'h101_03_2_0_00_00_00_2, 56'h101_e4_2_f_00_00_0f_2,
    56'h103_09_2_f_01_01_05_2, 56'h103_e5_2_f_01_00_01_2,
    56'h104_12_2_0_00_00_00_0, 56'h104_08_2_f_01_04_04_2,
    56'h105_03_2_f_31_04_03_2, 56'h103_0b_2_f_33_05_07_2,
    56'h103_19_2_0_00_00_00_0, 56'h103_00_2_f_30_04_00_2,
    56'h102_ff_2_f_00_00_00_0, 56'h600_02_2_f_00_00_00_1,
    56'h600_01_2_f_00_00_00_0};
  als_aux_model i_aux (.i_sys_clk(sys_clk), .o_req_valid(rv),
    .o_req_cmd(rc), .o_req_addr(ra), .o_req_data(rdt),
    .o_reply_ack(ak), .o_reply_nack(nk));
  als_snoop i_dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
    .i_cable_adapter_detect(cad), .i_aux_manchester_mode(man),
    .i_req_valid(rv), .i_req_cmd(rc), .i_req_addr(ra), .i_req_data(rdt),
    .i_reply_ack(ak), .i_reply_nack(nk), .o_output_swing_level(sw_q),
    .o_preemph_level(pe_q), .o_input_equalizer_setting(eq_q),
    .o_lane_en(ln_q), .o_link_rate(rt_q), .o_standby_d3(d3_q),
    .o_tmds_mode(tm_q), .o_rd_data(rd_q));
  // 250 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // compare, counting every call
  task automatic check(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // native write, then wait until the outputs have moved
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic nak, input int gap);
    i_aux.xfer(als_pkg::CMD_NATIVE_WR, {8'h00, a}, d, nak, gap);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic st(input logic [1:0] rte, input logic [3:0] lne);
    check("link_rate", 8'(rt_q), 8'(rte));
    check("lane_en", 8'(ln_q), 8'(lne));
  endtask : st
  task automatic dflt();
    st(2'h1, 4'h0);
    check("swing", 8'(sw_q), 8'h00);
    check("preemph", 8'(pe_q), 8'h00);
    check("rd_data", rd_q, 8'h00);
    check("standby_d3", 8'(d3_q), 8'h00);
    check("tmds_mode", 8'(tm_q), 8'h00);
  endtask : dflt
  // hang guard
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    reset_n = 1'h0;
    cad = 1'h0;
    man = 1'h1;
    repeat (8) @(posedge sys_clk);
    #1;
    dflt();
    @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    foreach (rows[i]) begin
      r = rows[i];
      wr(r.a, r.d, 1'h0, 0);
      st(r.rt[1:0], r.ln);
      check("standby_d3", 8'(d3_q), 8'(r.fl[0]));
      if (r.fl[1]) begin
        check("swing", 8'(sw_q), r.sw);
        check("preemph", 8'(pe_q), r.pe);
        check("equalizer", 8'(eq_q), r.pe);
        check("rd_data", rd_q, r.rd);
      end
    end
    // a nacked write changes nothing
    wr(12'h100, 8'h06, 1'h1, 0);
    st(2'h2, 4'hf);
    // a read changes nothing and shows the encoded rate
    i_aux.xfer(als_pkg::CMD_NATIVE_RD, 20'h00100, 8'h06, 1'h0, 0);
    repeat (3) @(posedge sys_clk);
    #1;
    st(2'h2, 4'hf);
    check("rd_data", rd_q, 8'h02);
    // slow sink still commits
    wr(12'h100, 8'h06, 1'h0, 6);
    st(2'h0, 4'hf);
    // outside manchester mode the observer stands still
    @(posedge sys_clk);
    man <= 1'h0;
    wr(12'h100, 8'h0a, 1'h0, 0);
    st(2'h0, 4'hf);
    @(posedge sys_clk);
    man <= 1'h1;
    // tmds mode blocks training writes
    cad <= 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
    check("tmds_mode", 8'(tm_q), 8'h01);
    wr(12'h100, 8'h0a, 1'h0, 0);
    st(2'h0, 4'hf);
    @(posedge sys_clk);
    cad <= 1'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    check("tmds_mode", 8'(tm_q), 8'h00);
    // back-to-back writes in dp mode
    i_aux.xfer(als_pkg::CMD_NATIVE_WR, 20'h00100, 8'h14, 1'h0, 0);
    wr(12'h101, 8'h02, 1'h0, 0);
    st(2'h2, 4'h3);
    // reset in mid-run, then a request right after release
    @(posedge sys_clk);
    reset_n <= 1'h0;
    @(posedge sys_clk);
    #1;
    dflt();
    @(posedge sys_clk);
    reset_n <= 1'h1;
    wr(12'h101, 8'h01, 1'h0, 0);
    st(2'h1, 4'h1);
    summarize();
  end
endmodule : tb
`default_nettype wire
